//--- logic/cmp_pkg.sv
package cmp_pkg;

  // Register byte addresses: four times the register index
  localparam logic [3:0]  IDX_CTRL    = 4'h0;
  localparam logic [3:0]  IDX_MUX     = 4'h2;
  localparam logic [3:0]  IDX_INTEN   = 4'h6;
  localparam logic [3:0]  IDX_STATUS  = 4'h7;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_MUX    = 12'h008;
  localparam logic [11:0] ADDR_INTEN  = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01C;
  localparam logic [11:0] ADDR_IMASK  = 12'h020;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LP_BIT     = 3;
  localparam int CTRL_PADOE_BIT  = 6;
  localparam int CTRL_STBY_BIT   = 7;
  localparam int MUX_INV_BIT     = 7;
  localparam int STAT_FLAG_BIT   = 0;
  localparam int STAT_LEVEL_BIT  = 4;
  localparam int INTEN_BIT       = 0;
  localparam int EDGE_LSB        = 4;
  localparam int HYST_LSB        = 1;
  localparam int POS_LSB         = 3;
  localparam int NEG_LSB         = 0;
  localparam int FIELD_W         = 2;

  // Writable masks
  localparam logic [7:0] CTRL_WMASK  = 8'hFF;
  localparam logic [7:0] MUX_WMASK   = 8'h9B;
  localparam logic [7:0] INTEN_WMASK = 8'h01;
  localparam logic [7:0] IMASK_WMASK = 8'h01;

  typedef enum logic [1:0] {
    EDGE_ANY      = 2'b00,
    EDGE_RESERVED = 2'b01,
    EDGE_FALL     = 2'b10,
    EDGE_RISE     = 2'b11
  } edge_sel_t;

  typedef enum logic [1:0] {
    HYST_OFF = 2'b00,
    HYST_10  = 2'b01,
    HYST_25  = 2'b10,
    HYST_50  = 2'b11
  } hyst_t;

  typedef enum logic [1:0] {
    POS_PIN_ZERO = 2'b00,
    POS_PIN_ONE  = 2'b01
  } pos_sel_t;

  typedef enum logic [1:0] {
    NEG_PIN_ZERO = 2'b00,
    NEG_PIN_ONE  = 2'b01,
    NEG_VREF     = 2'b10,
    NEG_DAC      = 2'b11
  } neg_sel_t;

  typedef enum logic [1:0] {
    PWR_OFF    = 2'b00,
    PWR_RUN    = 2'b01,
    PWR_FROZEN = 2'b10
  } pwr_state_t;

  // Analog core controls
  typedef struct packed {
    logic     enable;
    logic     low_power;
    hyst_t    hysteresis;
    pos_sel_t positive_input;
    neg_sel_t negative_input;
  } core_ctrl_t;

  // Sleep requests from the power manager
  typedef struct packed {
    logic standby;
    logic power_down;
  } sleep_t;

endpackage : cmp_pkg

//--- logic/level_sync.sv
`timescale 1ns/10ps
module level_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  logic mid_r;
  logic out_r;

  // Three stages give the status level lag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      mid_r  <= 1'b0;
      out_r  <= 1'b0;
    end else begin
      meta_r <= din;
      mid_r  <= meta_r;
      out_r  <= mid_r;
    end
  end

  assign dout = out_r;
endmodule : level_sync

//--- logic/comparator_control_regs.sv
`timescale 1ns/10ps
module comparator_control_regs
  import cmp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Power manager
  input  wire cmp_pkg::sleep_t   sleep_req,
  input  wire logic              clk_per_stopped,
  // Analog core
  output cmp_pkg::core_ctrl_t    core_ctrl,
  input  wire logic              core_out,
  // Event and pad
  output logic                   event_out,
  output logic                   pad_out,
  output logic                   pad_oe_n,
  // Interrupt
  output logic                   irq
);
  import cmp_pkg::*;

  // Register file
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  mux_r;
  logic [7:0]  mux_nxt;
  logic [7:0]  inten_r;
  logic [7:0]  inten_nxt;
  logic        imask_r;
  logic        imask_nxt;
  logic        flag_r;
  logic        flag_nxt;
  logic        state_r;
  logic        state_nxt;
  logic        level_prev_r;
  logic        level_prev_nxt;

  // Bus response
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;

  // Outputs toward the core, pad, event system and interrupt controller
  core_ctrl_t  core_ctrl_r;
  core_ctrl_t  core_ctrl_nxt;
  logic        event_r;
  logic        event_nxt;
  logic        pad_r;
  logic        pad_nxt;
  logic        pad_oe_n_r;
  logic        pad_oe_n_nxt;
  logic        irq_r;
  logic        irq_nxt;

  // Bus decode: setup phase loads read data, the ready access commits a write
  logic        setup_w;
  logic        access_w;
  logic        wr_w;
  logic        hit_ctrl;
  logic        hit_mux;
  logic        hit_inten;
  logic        hit_stat;
  logic        hit_imask;
  logic [7:0]  wbyte;

  assign setup_w   = psel & ~penable;
  assign access_w  = psel & penable & pready_r;
  assign wr_w      = access_w & pwrite & pstrb[0];
  assign hit_ctrl  = (paddr == ADDR_CTRL);
  assign hit_mux   = (paddr == ADDR_MUX);
  assign hit_inten = (paddr == ADDR_INTEN);
  assign hit_stat  = (paddr == ADDR_STATUS);
  assign hit_imask = (paddr == ADDR_IMASK);
  assign wbyte     = pwdata[7:0];

  // Power state
  logic        run_bit;
  logic        en_bit;
  logic        core_on;
  logic        updating;
  pwr_state_t  pwr_nxt;

  assign run_bit = ctrl_r[CTRL_STBY_BIT];
  assign en_bit  = ctrl_r[CTRL_ENABLE_BIT];

  always_comb begin
    pwr_nxt = PWR_RUN;
    if (!en_bit) begin
      pwr_nxt = PWR_OFF;
    end else if (sleep_req.power_down) begin
      pwr_nxt = PWR_OFF;
    end else if (sleep_req.standby && !run_bit) begin
      pwr_nxt = PWR_OFF;
    end else if (sleep_req.standby && clk_per_stopped) begin
      pwr_nxt = PWR_FROZEN;
    end
  end

  // The core stays powered while frozen; only the flag, status level and edge history halt
  assign core_on  = (pwr_nxt != PWR_OFF);
  assign updating = (pwr_nxt == PWR_RUN);

  // Output inversion ahead of every consumer
  logic        cmp_level;
  logic        lvl_sync;

  assign cmp_level = core_out ^ mux_r[MUX_INV_BIT];

  level_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (cmp_level),
    .dout  (lvl_sync)
  );

  // Edge detection on the synchronized level
  edge_sel_t   edge_mode;
  logic        rise_w;
  logic        fall_w;
  logic        edge_hit;
  logic        flag_set;
  logic        flag_clr;

  assign edge_mode = edge_sel_t'(ctrl_r[EDGE_LSB +: FIELD_W]);
  assign rise_w    = lvl_sync & ~level_prev_r;
  assign fall_w    = ~lvl_sync & level_prev_r;

  always_comb begin
    case (edge_mode)
      EDGE_ANY: begin
        edge_hit = rise_w | fall_w;
      end
      EDGE_FALL: begin
        edge_hit = fall_w;
      end
      EDGE_RISE: begin
        edge_hit = rise_w;
      end
      default: begin
        edge_hit = 1'b0;
      end
    endcase
  end

  assign flag_set = edge_hit & updating;
  assign flag_clr = wr_w & hit_stat & wbyte[STAT_FLAG_BIT];

  // Next register values; reserved bits are masked off on write
  assign ctrl_nxt  = (wr_w && hit_ctrl) ? (wbyte & CTRL_WMASK) : ctrl_r;
  assign mux_nxt   = (wr_w && hit_mux) ? (wbyte & MUX_WMASK) : mux_r;
  assign inten_nxt = (wr_w && hit_inten) ? (wbyte & INTEN_WMASK) : inten_r;
  assign imask_nxt = (wr_w && hit_imask) ? (wbyte[INTEN_BIT] & IMASK_WMASK[INTEN_BIT])
                                         : imask_r;

  // Set wins over a clear in the same cycle
  assign flag_nxt       = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_r);
  assign state_nxt      = updating ? lvl_sync : state_r;
  assign level_prev_nxt = updating ? lvl_sync : level_prev_r;

  // Read data selection
  logic [7:0]  status_byte;
  logic [7:0]  imask_byte;
  logic [7:0]  rd_byte;

  always_comb begin
    status_byte                 = RESET_BYTE;
    status_byte[STAT_FLAG_BIT]  = flag_r;
    status_byte[STAT_LEVEL_BIT] = state_r;
    imask_byte                  = RESET_BYTE;
    imask_byte[INTEN_BIT]       = imask_r;
  end

  assign rd_byte =
      hit_ctrl  ? ctrl_r :
      hit_mux   ? mux_r :
      hit_inten ? inten_r :
      hit_stat  ? status_byte :
      hit_imask ? imask_byte : RESET_BYTE;

  // No wait states; read data is loaded in the setup phase, never an error
  assign pready_nxt = setup_w;
  assign prdata_nxt = (setup_w && !pwrite) ? {24'h000000, rd_byte} : prdata_r;

  // Core, event and pad next values
  always_comb begin
    core_ctrl_nxt.enable         = core_on;
    core_ctrl_nxt.low_power      = ctrl_r[CTRL_LP_BIT];
    core_ctrl_nxt.hysteresis     = hyst_t'(ctrl_r[HYST_LSB +: FIELD_W]);
    core_ctrl_nxt.positive_input = pos_sel_t'(mux_r[POS_LSB +: FIELD_W]);
    core_ctrl_nxt.negative_input = neg_sel_t'(mux_r[NEG_LSB +: FIELD_W]);
  end

  assign event_nxt    = core_on & cmp_level;
  assign pad_nxt      = core_on & cmp_level;
  assign pad_oe_n_nxt = ~(core_on & ctrl_r[CTRL_PADOE_BIT]);
  // Request follows the next flag, so it falls at the very edge of the clear
  assign irq_nxt = flag_nxt & inten_nxt[INTEN_BIT] & ~imask_nxt;

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= RESET_BYTE;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_r <= RESET_BYTE;
    end else begin
      mux_r <= mux_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inten_r <= RESET_BYTE;
    end else begin
      inten_r <= inten_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      imask_r <= 1'b0;
    end else begin
      imask_r <= imask_nxt;
    end
  end

  // Flag, level and edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_prev_r <= 1'b0;
    end else begin
      level_prev_r <= level_prev_nxt;
    end
  end

  // Bus response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end

  // Output flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ctrl_r <= '0;
    end else begin
      core_ctrl_r <= core_ctrl_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_r <= 1'b0;
    end else begin
      event_r <= event_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_r <= 1'b0;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_oe_n_r <= 1'b1;
    end else begin
      pad_oe_n_r <= pad_oe_n_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = 1'b0;
  assign irq       = irq_r;
  assign core_ctrl = core_ctrl_r;
  assign event_out = event_r;
  assign pad_out   = pad_r;
  assign pad_oe_n  = pad_oe_n_r;
endmodule : comparator_control_regs

//--- sim/cmp_core_model.sv
`timescale 1ns/10ps
module cmp_core_model
  import cmp_pkg::*;
(
  // Controls and analog levels
  input  wire cmp_pkg::core_ctrl_t ctrl,
  input  wire logic [15:0]         vpos,
  input  wire logic [31:0]         vneg,
  // Output
  output logic                     cmp_out
);
  logic [7:0] vp;
  logic [7:0] vn;
  assign vp = vpos[8*ctrl.positive_input[0] +: 8];
  assign vn = vneg[8*ctrl.negative_input +: 8];
  // A switched-off core holds its output low
  assign cmp_out = ctrl.enable && (vp > vn);
endmodule : cmp_core_model

//--- sim/cmp_ctrl_monitor.sv
`timescale 1ns/10ps
module cmp_ctrl_monitor
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Power, core, pad, interrupt
  input wire cmp_pkg::sleep_t     sleep_req,
  input wire cmp_pkg::core_ctrl_t core_ctrl,
  input wire logic                event_out,
  input wire logic                pad_out,
  input wire logic                pad_oe_n,
  input wire logic                irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
  a_no_slverr: assert property (!pslverr) else $error("slave error");
  a_hole_zero: assert property (psel && !penable && !pwrite && paddr == 12'h004
    |=> prdata == '0) else $error("hole read not zero");
  a_upper_zero: assert property (pready |-> prdata[31:8] == '0) else $error("upper bits");
  a_pd_off: assert property (sleep_req.power_down
    |=> !core_ctrl.enable && pad_oe_n && !event_out) else $error("power down");
  a_pad_match: assert property (!pad_oe_n |-> pad_out == event_out) else $error("pad");
  a_event_gate: assert property (event_out |-> core_ctrl.enable) else $error("event");
  a_irq_hold: assert property (irq && !psel |=> irq) else $error("irq dropped");
endmodule : cmp_ctrl_monitor

bind comparator_control_regs cmp_ctrl_monitor i_mon (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_req(sleep_req), .core_ctrl(core_ctrl), .event_out(event_out),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n), .irq(irq));

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
  import cmp_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, cps = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, vneg = 32'h8080_8080;
  logic [15:0] vpos = '0;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, event_out, pad_out, pad_oe_n, irq, core_out;
  sleep_t      sleep_req = '0;
  core_ctrl_t  core_ctrl;
  int          errors = 0, checks = 0, seed = 83481, c, m;
  always #5 clk = ~clk;
  comparator_control_regs i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .clk_per_stopped(cps),
    .core_ctrl(core_ctrl), .core_out(core_out), .event_out(event_out), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .irq(irq));
  cmp_core_model i_core (.ctrl(core_ctrl), .vpos(vpos), .vneg(vneg), .cmp_out(core_out));
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    if (pready !== 1'b1) errors++;
    rd = prdata;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk("prdata", x, rd);
  endtask : rdc
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(ADDR_CTRL, 0);
    rdc(ADDR_MUX, 0);
    rdc(ADDR_INTEN, 0);
    rdc(ADDR_STATUS, 0);
    apb(1'b1, 12'h004, 32'hFF);
    rdc(12'h004, 0);
    for (int i = 0; i < 4; i++) begin
      c = ($random(seed) & 8'h39) | (i << 1);
      m = ($random(seed) & 8'hFC) | i;
      apb(1'b1, ADDR_CTRL, c);
      apb(1'b1, ADDR_MUX, m);
      rdc(ADDR_CTRL, c);
      rdc(ADDR_MUX, m & 8'h9B);
      chk("core", {c[0], c[3], c[2:1], m[4:3], m[1:0]}, core_ctrl);
    end
    apb(1'b1, ADDR_MUX, 0);
    apb(1'b1, ADDR_INTEN, 1);
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, ADDR_CTRL, 8'h41 | (e << 4));
      apb(1'b1, ADDR_STATUS, 1);
      vpos[7:0] <= 8'hFF;
      repeat (8) @(posedge clk);
      rdc(ADDR_STATUS, 32'h10 | (e == 0 || e == 3));
      chk("irq", e == 0 || e == 3, irq);
      apb(1'b1, ADDR_STATUS, 0);
      rdc(ADDR_STATUS, 32'h10 | (e == 0 || e == 3));
      apb(1'b1, ADDR_STATUS, 1);
      vpos[7:0] <= 8'h00;
      repeat (8) @(posedge clk);
      rdc(ADDR_STATUS, e == 0 || e == 2);
    end
    apb(1'b1, ADDR_MUX, 8'h80);
    repeat (8) @(posedge clk);
    rdc(ADDR_STATUS, 32'h11);
    chk("event", 1, event_out);
    chk("pad", 2, {pad_out, pad_oe_n});
    chk("irq", 1, irq);
    apb(1'b1, ADDR_INTEN, 0);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    rdc(ADDR_STATUS, 32'h11);
    sleep_req.power_down <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pd", 1, {core_ctrl.enable, pad_oe_n});
    sleep_req <= 2'b10;
    repeat (3) @(posedge clk);
    chk("halt", 0, core_ctrl.enable);
    apb(1'b1, ADDR_CTRL, 8'hC1);
    repeat (2) @(posedge clk);
    chk("run", 1, core_ctrl.enable);
    apb(1'b1, ADDR_STATUS, 1);
    cps <= 1'b1;
    vpos[7:0] <= 8'hFF;
    repeat (8) @(posedge clk);
    rdc(ADDR_STATUS, 32'h10);
    cps <= 1'b0;
    sleep_req <= '0;
    repeat (8) @(posedge clk);
    rdc(ADDR_STATUS, 32'h01);
    stop_test();
  end
endmodule : tb
